// ===== etm_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Pause bit high halts counting; low resumes normal counting.
// RULE2 - While paused counter holds; resumes from held value, not zero.
// RULE3 - Clock source field picks sys/4, sys, hs/16, hs/64, time-base, ext edges.
// RULE4 - Reserved clock code gives no clock; counter stays still.
// RULE5 - On bit rising clears counter; falling keeps residual value.
// RULE6 - On bit low stops counter and timer; high lets it run.
// RULE7 - Compare mode: on bit rising restores pin to initial level.
// RULE8 - Period value compared with counter bits 9..7; 128-clock multiples.
// RULE9 - Period value zero: no early clear, counter overflows at maximum.
// RULE10 - Mode field: compare, capture, PWM/single pulse, timer/counter.
// RULE11 - Software turns timer off before changing mode field.
// RULE12 - Software keeps pin output disabled in timer/counter mode.
// RULE13 - Compare match A: no change, low, high or toggle pin.
// RULE14 - PWM mode pin function: inactive, active, PWM, single pulse.
// RULE15 - Capture mode edge select: rising, falling, both, disabled.
// RULE16 - Match level equal to initial level shows no pin change.
// RULE17 - Software changes pin function in PWM only while timer off.
// RULE18 - Output control sets initial level or PWM active level.
// RULE19 - Polarity bit inverts pin output; no effect in timer mode.
// RULE20 - Read-only direction flag: 0 up, 1 down; writes ignored.
// RULE21 - Clear select 1: match A clears; 0: period match or overflow.
// RULE22 - Clear select ignored in PWM, single pulse and capture modes.
// RULE23 - Counter and compare values are ten bits, full width compare.
// RULE24 - Overflow or clearing match raises the timer event pulse.
module etm_ctrl
    import etm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire axi_req_s axi_req,
    output axi_rsp_s axi_rsp,
    input wire logic hs_tick,
    input wire logic tbc_tick,
    input wire logic ext_count_in,
    input wire logic chan_a_pin_in,
    output logic chan_a_pin_out,
    output logic chan_a_pin_oe,
    output logic timer_event
);

    typedef struct packed
    {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [9:0] cmp_a;
        logic [COUNT_W-1:0] count;
        logic on_prev;
        logic pin_raw;
        logic pulse_run;
        logic cap_prev;
        logic pin_out;
        logic pin_oe;
        logic event_p;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        axi_rsp_s rsp;
    } ctrl_st_s;

    ctrl_st_s st_q;
    ctrl_st_s st_d;
    logic tick;

    // =====================================================================
    // Count clock source
    // =====================================================================
    etm_tick_gen u_tick
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_sel(st_q.ctrl0[CLK_SEL_LSB +: 3]),
        .hs_tick(hs_tick),
        .tbc_tick(tbc_tick),
        .ext_in(ext_count_in),
        .tick(tick)
    );

    // Field views of the control registers
    logic pause;
    logic timer_on;
    logic [2:0] period;
    chan_mode_e mode;
    logic [1:0] pin_fn;
    logic out_ctrl;
    logic polarity;
    logic clr_sel;
    assign pause = st_q.ctrl0[PAUSE_BIT];
    assign timer_on = st_q.ctrl0[ON_BIT];
    assign period = st_q.ctrl0[PERIOD_LSB +: 3];
    assign mode = chan_mode_e'(st_q.ctrl1[MODE_LSB +: 2]);
    assign pin_fn = st_q.ctrl1[PIN_FN_LSB +: 2];
    assign out_ctrl = st_q.ctrl1[OUT_CTRL_BIT];
    assign polarity = st_q.ctrl1[POLARITY_BIT];
    assign clr_sel = st_q.ctrl1[CLR_SEL_BIT];

    // =====================================================================
    // Next-state logic
    // =====================================================================
    // Bus handshake, counter, comparators and pin logic in one pass
    always_comb
    begin
        logic running;
        logic on_rise;
        logic match_a;
        logic match_p;
        logic at_max;
        logic clear_cnt;
        logic [COUNT_W-1:0] cnt_next;
        logic cap_edge;
        logic [31:0] wmask;
        logic [31:0] merged;
        running = 1'b0;
        on_rise = 1'b0;
        match_a = 1'b0;
        match_p = 1'b0;
        at_max = 1'b0;
        clear_cnt = 1'b0;
        cnt_next = '0;
        cap_edge = 1'b0;
        wmask = '0;
        merged = '0;
        st_d = st_q;
        st_d.event_p = 1'b0;
        st_d.on_prev = timer_on;
        st_d.cap_prev = chan_a_pin_in;

        // Counter: on bit edge clears, pause holds the residual value
        on_rise = timer_on && !st_q.on_prev; // RULE5
        running = timer_on && !pause && tick; // RULE1 RULE2 RULE6
        if (mode == MODE_PWM && pin_fn == 2'b11)
        begin
            running = running && st_q.pulse_run;
        end
        match_a = (st_q.count == st_q.cmp_a); // RULE23
        // Look one count ahead so each period step spans exactly 128 ticks
        cnt_next = st_q.count + 10'd1;
        match_p = (period != 3'b000) && (cnt_next[9:7] == period); // RULE8
        at_max = (st_q.count == '1);
        if (mode == MODE_COMPARE || mode == MODE_TIMER)
        begin
            // RULE21
            clear_cnt = clr_sel ? match_a : (period == 3'b000 ? at_max : match_p); // RULE9
        end
        else if (mode == MODE_CAPTURE)
        begin
            clear_cnt = (period == 3'b000) ? at_max : match_p; // RULE22
        end
        else
        begin
            clear_cnt = pin_fn == 2'b11 ? 1'b0 : (period == 3'b000 ? at_max : match_p); // RULE22
        end

        if (on_rise)
        begin
            st_d.count = '0; // RULE5
            st_d.pulse_run = 1'b1;
        end
        else if (running)
        begin
            if (clear_cnt)
            begin
                st_d.count = '0;
                st_d.event_p = 1'b1; // RULE24
            end
            else
            begin
                st_d.count = st_q.count + 10'd1;
            end
        end

        // Channel A pin behaviour by mode
        case (mode) // RULE10
            MODE_COMPARE:
            begin
                if (on_rise)
                begin
                    st_d.pin_raw = out_ctrl; // RULE7 RULE18
                end
                else if (running && match_a)
                begin
                    // Requested level equal to current gives no visible change
                    case (pin_fn) // RULE13 RULE16
                        2'b01: st_d.pin_raw = 1'b0;
                        2'b10: st_d.pin_raw = 1'b1;
                        2'b11: st_d.pin_raw = !st_q.pin_raw;
                        default: st_d.pin_raw = st_q.pin_raw;
                    endcase
                    if (clr_sel == 1'b0)
                    begin
                        st_d.event_p = 1'b1;
                    end
                end
            end
            MODE_PWM:
            begin
                // Active level comes from output control
                case (pin_fn) // RULE14 RULE18
                    2'b00: st_d.pin_raw = !out_ctrl;
                    2'b01: st_d.pin_raw = out_ctrl;
                    2'b10: st_d.pin_raw = timer_on && (st_q.count < st_q.cmp_a) ? out_ctrl
                                                                                : !out_ctrl;
                    default:
                    begin
                        if (running && match_a)
                        begin
                            st_d.pulse_run = 1'b0;
                            st_d.event_p = 1'b1;
                        end
                        st_d.pin_raw = (timer_on && st_d.pulse_run) ? out_ctrl : !out_ctrl;
                    end
                endcase
            end
            MODE_CAPTURE:
            begin
                case (pin_fn) // RULE15
                    2'b00: cap_edge = chan_a_pin_in && !st_q.cap_prev;
                    2'b01: cap_edge = !chan_a_pin_in && st_q.cap_prev;
                    2'b10: cap_edge = chan_a_pin_in != st_q.cap_prev;
                    default: cap_edge = 1'b0;
                endcase
                if (cap_edge && timer_on)
                begin
                    st_d.cmp_a = st_q.count;
                    st_d.event_p = 1'b1;
                end
            end
            default:
            begin
                st_d.pin_raw = st_q.pin_raw;
            end
        endcase

        // Polarity and enable; timer mode leaves the pin to the port logic
        st_d.pin_out = st_d.pin_raw ^ polarity; // RULE19
        st_d.pin_oe = (mode == MODE_COMPARE) || (mode == MODE_PWM);

        // AXI write: address and data taken in either order
        st_d.rsp.awready = 1'b0;
        st_d.rsp.wready = 1'b0;
        st_d.rsp.arready = 1'b0;
        if (axi_req.awvalid && !st_q.aw_got && !st_q.rsp.awready && !st_q.rsp.bvalid)
        begin
            st_d.rsp.awready = 1'b1;
            st_d.aw_got = 1'b1;
            st_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st_q.w_got && !st_q.rsp.wready && !st_q.rsp.bvalid)
        begin
            st_d.rsp.wready = 1'b1;
            st_d.w_got = 1'b1;
            st_d.w_data = axi_req.wdata;
            st_d.w_strb = axi_req.wstrb;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.rsp.bvalid)
        begin
            wmask = {{8{st_q.w_strb[3]}}, {8{st_q.w_strb[2]}},
                     {8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp = AXI_OKAY;
            if (st_q.aw_addr == ADDR_CTRL_ZERO)
            begin
                merged = ({24'h00_0000, st_q.ctrl0} & ~wmask) | (st_q.w_data & wmask);
                st_d.ctrl0 = merged[7:0];
            end
            else if (st_q.aw_addr == ADDR_CTRL_ONE)
            begin
                merged = ({24'h00_0000, st_q.ctrl1} & ~wmask) | (st_q.w_data & wmask);
                st_d.ctrl1 = merged[7:0];
                st_d.ctrl1[DIR_BIT] = 1'b0; // RULE20
            end
            else if (st_q.aw_addr == ADDR_CMP_A)
            begin
                merged = ({22'h00_0000, st_q.cmp_a} & ~wmask) | (st_q.w_data & wmask);
                st_d.cmp_a = merged[9:0];
            end
            else if (st_q.aw_addr != ADDR_COUNT)
            begin
                st_d.rsp.bresp = AXI_SLVERR;
            end
        end
        else if (st_q.rsp.bvalid && axi_req.bready)
        begin
            st_d.rsp.bvalid = 1'b0;
        end

        // AXI read: data valid in the same cycle the address is taken
        if (axi_req.arvalid && !st_q.rsp.arready && !st_q.rsp.rvalid)
        begin
            st_d.rsp.arready = 1'b1;
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rresp = AXI_OKAY;
            if (axi_req.araddr == ADDR_CTRL_ZERO)
            begin
                st_d.rsp.rdata = {24'h00_0000, st_q.ctrl0};
            end
            else if (axi_req.araddr == ADDR_CTRL_ONE)
            begin
                // Counter only counts up, so the direction flag reads zero
                st_d.rsp.rdata = {24'h00_0000, st_q.ctrl1}; // RULE20
            end
            else if (axi_req.araddr == ADDR_COUNT)
            begin
                st_d.rsp.rdata = {22'h00_0000, st_q.count};
            end
            else if (axi_req.araddr == ADDR_CMP_A)
            begin
                st_d.rsp.rdata = {22'h00_0000, st_q.cmp_a};
            end
            else
            begin
                st_d.rsp.rdata = 32'h0000_0000;
                st_d.rsp.rresp = AXI_SLVERR;
            end
        end
        else if (st_q.rsp.rvalid && axi_req.rready)
        begin
            st_d.rsp.rvalid = 1'b0;
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.ctrl0 <= CTRL_ZERO_RESET;
            st_q.ctrl1 <= CTRL_ONE_RESET;
            st_q.cmp_a <= CMP_A_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign axi_rsp = st_q.rsp;
    assign chan_a_pin_out = st_q.pin_out;
    assign chan_a_pin_oe = st_q.pin_oe;
    assign timer_event = st_q.event_p;

endmodule

// ===== etm_ctrl_asserts.sv
`timescale 1ns/1ps
// ====
// Port checker for the timer control block
module etm_ctrl_asserts
    import etm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire axi_req_s axi_req,
    input wire axi_rsp_s axi_rsp,
    input wire logic chan_a_pin_oe,
    input wire logic timer_event
);
    logic [7:0] wa_q;
    logic [7:0] wd_q;
    logic [7:0] c0_q;
    logic [7:0] c1_q;
    logic bv_q;
    logic arm_q;
    logic [14:0] gap_q;
    logic [1:0] mode;
    logic [10:0] per;

    // Expected period; shadows lag the design by one cycle
    assign mode = c1_q[7:6];
    assign per = (c0_q[2:0] == 3'h0) ? 11'h400 : {1'b0, c0_q[2:0], 7'h00};

    // Shadow control registers and gap counter between events
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            c0_q <= 8'h00;
            c1_q <= 8'h00;
            bv_q <= 1'b0;
            arm_q <= 1'b0;
            gap_q <= 15'h0000;
        end
        else
        begin
            bv_q <= axi_rsp.bvalid;
            gap_q <= timer_event ? 15'h0001 : gap_q + 15'h0001;
            // Any write breaks the running interval, so disarm
            arm_q <= (timer_event | arm_q) & ~(axi_rsp.bvalid & ~bv_q);
            if (axi_req.awvalid && axi_rsp.awready)
                wa_q <= axi_req.awaddr;
            if (axi_req.wvalid && axi_rsp.wready)
                wd_q <= axi_req.wdata[7:0];
            if (axi_rsp.bvalid && !bv_q && wa_q == ADDR_CTRL_ZERO)
                c0_q <= wd_q;
            if (axi_rsp.bvalid && !bv_q && wa_q == ADDR_CTRL_ONE)
                c1_q <= wd_q;
        end
    end

    // ====
    // Properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence

    property p_wr_resp;
        s_wr_taken |=> axi_rsp.bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response missing");
    property p_rd_unmapped;
        s_rd_taken ##0 (axi_req.araddr > ADDR_CMP_A) |->
            axi_rsp.rresp == AXI_SLVERR && axi_rsp.rdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not refused");
    property p_dir_flag;
        s_rd_taken ##0 (axi_req.araddr == ADDR_CTRL_ONE) |-> !axi_rsp.rdata[DIR_BIT];
    endproperty
    a_dir_flag: assert property (p_dir_flag)
        else $error("direction flag not zero");
    property p_off_quiet;
        !c0_q[ON_BIT] && !$past(c0_q[ON_BIT]) && mode != MODE_CAPTURE |-> !timer_event;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("event while timer off");
    property p_pause_quiet;
        c0_q[PAUSE_BIT] && $past(c0_q[PAUSE_BIT]) && mode != MODE_CAPTURE |-> !timer_event;
    endproperty
    a_pause_quiet: assert property (p_pause_quiet)
        else $error("event while paused");
    property p_rsvd_quiet;
        c0_q[6:4] == CK_RSVD && $past(c0_q[6:4]) == CK_RSVD && mode != MODE_CAPTURE
            |-> !timer_event;
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet)
        else $error("event with reserved clock");
    property p_no_pin;
        (mode == MODE_TIMER || mode == MODE_CAPTURE) && $past(c1_q[7:6]) == mode
            |-> !chan_a_pin_oe;
    endproperty
    a_no_pin: assert property (p_no_pin)
        else $error("pin driven in input mode");
    property p_period;
        timer_event && arm_q && mode == MODE_TIMER && !c1_q[CLR_SEL_BIT]
            && c0_q[6:4] == CK_SYS |-> gap_q == {4'h0, per};
    endproperty
    a_period: assert property (p_period)
        else $error("clear period wrong");
endmodule

// ===== etm_pkg.sv
package etm_pkg;

    // =====================================================================
    // Register map (byte addresses, one aligned word each)
    // =====================================================================
    localparam logic [7:0] ADDR_CTRL_ZERO = 8'h00;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CMP_A = 8'h0C;

    localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [9:0] CMP_A_RESET = 10'h000;

    // Field positions, control zero
    localparam int PAUSE_BIT = 7;
    localparam int CLK_SEL_LSB = 4;
    localparam int ON_BIT = 3;
    localparam int PERIOD_LSB = 0;
    // Field positions, control one
    localparam int MODE_LSB = 6;
    localparam int PIN_FN_LSB = 4;
    localparam int OUT_CTRL_BIT = 3;
    localparam int POLARITY_BIT = 2;
    localparam int DIR_BIT = 1;
    localparam int CLR_SEL_BIT = 0;

    // Prescaler ratios
    localparam int DIV_SYS = 4;
    localparam int DIV_HS_A = 16;
    localparam int DIV_HS_B = 64;

    localparam int COUNT_W = 10;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    // =====================================================================
    // Enumerations
    // =====================================================================
    typedef enum logic [2:0]
    {
        CK_SYS_DIV4 = 3'b000,
        CK_SYS = 3'b001,
        CK_HS_DIV16 = 3'b010,
        CK_HS_DIV64 = 3'b011,
        CK_TBC = 3'b100,
        CK_RSVD = 3'b101,
        CK_EXT_RISE = 3'b110,
        CK_EXT_FALL = 3'b111
    } clk_sel_e;

    typedef enum logic [1:0]
    {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } chan_mode_e;

    // =====================================================================
    // Carriers
    // =====================================================================
    typedef struct packed
    {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    typedef struct packed
    {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_s;

endpackage

// ===== etm_tick_gen.sv
`timescale 1ns/1ps
// Produces the one-cycle count tick from the selected clock source
module etm_tick_gen
    import etm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] clk_sel,
    input wire logic hs_tick,
    input wire logic tbc_tick,
    input wire logic ext_in,
    output logic tick
);

    typedef struct packed
    {
        logic [1:0] sys_div;
        logic [5:0] hs_div;
        logic ext_prev;
        logic tick;
    } tick_st_s;

    tick_st_s st_q;
    tick_st_s st_d;

    // =====================================================================
    // Prescalers and source select
    // =====================================================================
    // Prescalers run free so a source switch does not need a restart
    always_comb
    begin
        st_d = st_q;
        st_d.sys_div = st_q.sys_div + 2'd1;
        st_d.ext_prev = ext_in;
        if (hs_tick)
        begin
            st_d.hs_div = st_q.hs_div + 6'd1;
        end
        case (clk_sel_e'(clk_sel)) // RULE3
            CK_SYS_DIV4: st_d.tick = (st_q.sys_div == 2'(DIV_SYS - 1));
            CK_SYS: st_d.tick = 1'b1;
            CK_HS_DIV16: st_d.tick = hs_tick && (st_q.hs_div[3:0] == 4'(DIV_HS_A - 1));
            CK_HS_DIV64: st_d.tick = hs_tick && (st_q.hs_div == 6'(DIV_HS_B - 1));
            CK_TBC: st_d.tick = tbc_tick;
            CK_EXT_RISE: st_d.tick = ext_in && !st_q.ext_prev;
            CK_EXT_FALL: st_d.tick = !ext_in && st_q.ext_prev;
            default: st_d.tick = 1'b0; // RULE4
        endcase
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule

// ===== tb_enhanced_timer_control_regs.sv
`timescale 1ns/1ps
module tb_enhanced_timer_control_regs
    import etm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hs_tick = 1'b0;
    logic tbc_tick = 1'b0;
    logic ext_count_in = 1'b0;
    logic pin_in = 1'b0;
    axi_req_s axi_req = '0;
    axi_rsp_s axi_rsp;
    logic pin_out;
    logic pin_oe;
    logic ev;
    logic [1:0] resp;
    logic [31:0] rdat;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;

    // ====
    // Clock and sources; each source pulses every other cycle
    always #5 sys_clk = ~sys_clk;

    // Sources and watchdog; a hang ends in the report
    always @(posedge sys_clk)
    begin
        hs_tick <= ~hs_tick;
        tbc_tick <= ~tbc_tick;
        ext_count_in <= ~ext_count_in;
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            fails = fails + 1;
            final_report();
        end
    end

    etm_ctrl dut_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .hs_tick(hs_tick),
        .tbc_tick(tbc_tick),
        .ext_count_in(ext_count_in),
        .chan_a_pin_in(pin_in),
        .chan_a_pin_out(pin_out),
        .chan_a_pin_oe(pin_oe),
        .timer_event(ev)
    );

    // ====
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        axi_req.awaddr <= a;
        axi_req.wdata <= 32'(d);
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (axi_rsp.awready === 1'b1)
                axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready === 1'b1)
                axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (axi_rsp.arready === 1'b1)
                axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        rdat = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Cycles until the next event, or lim if none
    task automatic wait_ev(input int lim);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n = n + 1;
        end while (ev !== 1'b1 && n < lim);
    endtask

    // Mode is only changed with the timer off
    task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
        wr(ADDR_CTRL_ZERO, 8'h00);
        wr(ADDR_CTRL_ONE, c1);
        wr(ADDR_CTRL_ZERO, c0);
    endtask

    task final_report;
        $display("mismatches %0d comparisons %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ====
    // Scenarios
    task automatic t_regs();
        rd(ADDR_CTRL_ZERO);
        chk(rdat, 32'(CTRL_ZERO_RESET));
        rd(ADDR_CTRL_ONE);
        chk(rdat, 32'(CTRL_ONE_RESET));
        rd(ADDR_CMP_A);
        chk(rdat, 32'(CMP_A_RESET));
        wr(ADDR_CTRL_ONE, 8'hff);
        rd(ADDR_CTRL_ONE);
        chk(rdat, 32'h0000_00fd);
        wr(ADDR_COUNT, 8'h55);
        chk(32'(resp), 32'(AXI_OKAY));
        wr(8'h10, 8'h01);
        chk(32'(resp), 32'(AXI_SLVERR));
        rd(8'h10);
        chk(32'(resp), 32'(AXI_SLVERR));
        chk(rdat, 32'h0);
    endtask

    task automatic t_period();
        int ps[3] = '{1, 7, 0};
        foreach (ps[i])
        begin
            cfg(8'hc0, 8'h18 | 8'(ps[i]));
            wait_ev(1100);
            wait_ev(1100);
            chk(n, ps[i] == 0 ? 1024 : 128 * ps[i]);
            chk(32'(pin_oe), 32'h0);
        end
    endtask

    // Pause keeps the count; off then on restarts from zero
    task automatic t_run();
        cfg(8'hc0, 8'h19);
        wait_ev(200);
        repeat (100) @(posedge sys_clk);
        wr(ADDR_CTRL_ZERO, 8'h99);
        wait_ev(300);
        chk(n, 300);
        wr(ADDR_CTRL_ZERO, 8'h19);
        wait_ev(200);
        chk(32'(n < 60), 32'h1);
        repeat (100) @(posedge sys_clk);
        wr(ADDR_CTRL_ZERO, 8'h11);
        wait_ev(300);
        chk(n, 300);
        wr(ADDR_CTRL_ZERO, 8'h19);
        wait_ev(200);
        chk(32'(n > 119 && n < 131), 32'h1);
    endtask

    task automatic t_clk();
        int exp[8] = '{512, 128, 4096, 16384, 256, 0, 256, 256};
        for (int c = 0; c < 8; c++)
        begin
            cfg(8'hc0, {1'b0, 3'(c), 4'h9});
            wait_ev(c == 5 ? 1500 : 20000);
            if (c != 5)
                wait_ev(20000);
            chk(n, c == 5 ? 1500 : exp[c]);
        end
    endtask

    task automatic t_cmp();
        logic f1;
        logic f0;
        logic oc;
        logic pol;
        logic lvl;
        wr(ADDR_CMP_A, 8'h0a);
        for (int k = 0; k < 8; k++)
        begin
            {oc, f1, f0} = 3'(k);
            pol = f1 ^ oc;
            lvl = (f1 == f0) ? (f1 ? ~oc : oc) : f1;
            cfg({2'b00, f1, f0, oc, pol, 2'b00}, 8'h19);
            repeat (3) @(posedge sys_clk);
            chk(32'(pin_out), 32'(oc ^ pol));
            chk(32'(pin_oe), 32'h1);
            wait_ev(200);
            repeat (2) @(posedge sys_clk);
            chk(32'(pin_out), 32'(lvl ^ pol));
            wr(ADDR_CTRL_ZERO, 8'h11);
            wr(ADDR_CTRL_ZERO, 8'h19);
            repeat (3) @(posedge sys_clk);
            chk(32'(pin_out), 32'(oc ^ pol));
        end
    endtask

    // PWM and single pulse, active high; clear select set but must be ignored
    task automatic t_pwm();
        wr(ADDR_CMP_A, 8'h20);
        for (int f = 0; f < 4; f++)
        begin
            cfg({2'b10, 2'(f), 4'h9}, 8'h19);
            repeat (5) @(posedge sys_clk);
            chk(32'(pin_out), 32'(f != 0));
            wait_ev(200);
            repeat (40) @(posedge sys_clk);
            chk(32'(pin_out), 32'(f == 1));
        end
    endtask

    task automatic t_cap();
        for (int f = 0; f < 4; f++)
        begin
            cfg({2'b01, 2'(f), 4'h0}, 8'h18);
            pin_in <= 1'b1;
            wait_ev(8);
            chk(32'(n < 8), 32'(f == 0 || f == 2));
            pin_in <= 1'b0;
            wait_ev(8);
            chk(32'(n < 8), 32'(f == 1 || f == 2));
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_period();
        t_run();
        t_clk();
        t_cmp();
        t_pwm();
        t_cap();
        final_report();
    end
endmodule

bind etm_ctrl etm_ctrl_asserts chk_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .chan_a_pin_oe(chan_a_pin_oe),
    .timer_event(timer_event)
);
